// ==== bench/host_reader.sv ====
// host model: makes register reads on the device register port
// assumes each read is a one-cycle strobe answered one cycle later
`timescale 1ns/1ps
module host_reader (
    input wire logic clk_i,
    input wire logic [9:0] reg_rdata_i,
    input wire logic reg_rvalid_i,
    output logic [7:0] reg_addr_o,
    output logic reg_read_o
);
    ////////////////////////////////////////////////////////////
    // idle: strobe low, address parked on a pattern
    initial begin
        reg_read_o = 1'b0;
        reg_addr_o = 8'hA5;
    end

    // strobe lasts one cycle only, a longer one would be a second read
    task automatic read(input logic [7:0] a, output logic [9:0] d);
        @(negedge clk_i);
        reg_addr_o = a;
        reg_read_o = 1'b1;
        @(negedge clk_i);
        reg_read_o = 1'b0;
        reg_addr_o = ~a; // released, so a stale address is never reused
        d = (reg_rvalid_i === 1'b1) ? reg_rdata_i : 10'hXXX; // late answer fails
    endtask : read
endmodule : host_reader

// ==== bench/tb.sv ====
// self-checking bench for the led monitor and fault status registers
// assumes host_reader makes every read; stores and levels are driven here
`timescale 1ns/1ps
module tb;
    import fault_mon_pkg::*;
    logic clk_i, rst_i, rd_strobe, rvalid, ot, cs, alt, sum_v;
    logic [2:0] st;
    logic [7:0] addr;
    logic [9:0] rdata;
    logic [3:0] sum;
    logic [7:0] v [0:2];
    logic [7:0] c [0:2];
    logic [6:0] s [0:2];
    logic [7:0] th [0:2];
    int err_total = 0;
    int check_count = 0;
    int cyc = 0;

    ////////////////////////////////////////////////////////////
    // index 0 carries the temperature, 1 and 2 the channels
    led_monitor_fault_status i_led_monitor_fault_status (
        .clk_i(clk_i), .rst_i(rst_i), .reg_addr_i(addr), .reg_read_i(rd_strobe),
        .reg_rdata_o(rdata), .reg_rvalid_o(rvalid),
        .ch1_store_i(st[1]), .output_voltage_code_ch1_i(v[1]), .current_code_ch1_i(c[1]),
        .current_setting_ch1_i(s[1]), .short_threshold_ch1_i(th[1]),
        .ch2_store_i(st[2]), .output_voltage_code_ch2_i(v[2]), .current_code_ch2_i(c[2]),
        .current_setting_ch2_i(s[2]), .short_threshold_ch2_i(th[2]),
        .temp_store_i(st[0]), .temp_code_i(v[0]), .overtemp_pin_i(ot),
        .channel_select_setting_i(cs), .status_alternate_select_i(alt),
        .summary_fault_bits_o(sum), .summary_valid_o(sum_v)
    );
    host_reader i_host_reader (.clk_i(clk_i), .reg_rdata_i(rdata),
        .reg_rvalid_i(rvalid), .reg_addr_o(addr), .reg_read_o(rd_strobe));

    // 50 ns clock
    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end

    // hang guard, far above the few hundred cycles the sequence needs
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            err_total++;
            print_verdict();
        end
    end

    ////////////////////////////////////////////////////////////
    // closing report
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : print_verdict

    // compare with case equality so an unknown never matches
    task automatic chk(input string what, input logic [9:0] e, input logic [9:0] g);
        check_count++;
        if (g !== e) begin
            err_total++;
            $display("BAD %s expected %h seen %h", what, e, g);
        end
    endtask : chk

    task automatic rd(input logic [7:0] a, input logic [9:0] e);
        logic [9:0] d;
        i_host_reader.read(a, d);
        chk($sformatf("register %h", a), e, d);
    endtask : rd

    // values presented together with a one-cycle store strobe
    task automatic meas(input int ch, input logic [7:0] vn, cn, input logic [6:0] sn,
            input logic [7:0] tn);
        @(negedge clk_i);
        v[ch] = vn;
        c[ch] = cn;
        s[ch] = sn;
        th[ch] = tn;
        st[ch] = 1'b1;
        @(negedge clk_i);
        st = 3'b000;
    endtask : meas

    // settings below the enable minimum keep the current checks quiet
    task automatic calm();
        meas(1, 8'h80, 8'h00, 7'h00, 8'h00);
        meas(2, 8'h80, 8'h00, 7'h00, 8'h00);
        meas(0, 8'h00, 8'h00, 7'h00, 8'h00);
    endtask : calm

    // raise a condition, show it held through reads, then let it clear
    task automatic flt(input int ch, input logic [7:0] vn, cn, input logic [6:0] sn,
            input logic [7:0] tn, input logic [9:0] e, input logic [3:0] se);
        meas(ch, vn, cn, sn, tn);
        rd(OFS_FAULT_STATUS, e);
        chk("summary", {6'h00, se}, {6'h00, sum});
        rd(OFS_FAULT_STATUS, e);
        calm();
        rd(OFS_FAULT_STATUS, e);
        rd(OFS_FAULT_STATUS, 10'h000);
    endtask : flt

    ////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        rst_i = 1'b1;
        st = 3'b000;
        {ot, cs, alt} = 3'b000;
        v = '{default: 8'h00};
        c = '{default: 8'h00};
        s = '{default: 7'h00};
        th = '{default: 8'h00};
        repeat (20) @(negedge clk_i);
        rst_i = 1'b0;
        rd(OFS_LED_CURRENT_CH2, 10'h000);
        rd(OFS_DIE_TEMPERATURE, 10'h000);
        rd(OFS_FAULT_STATUS, 10'h000);
        meas(2, 8'h80, 8'h5A, 7'h00, 8'h00);
        meas(1, 8'h80, 8'h77, 7'h00, 8'h00);
        rd(OFS_LED_CURRENT_CH2, 10'h05A);
        meas(0, 8'h3C, 8'h00, 7'h00, 8'h00);
        rd(OFS_DIE_TEMPERATURE, 10'h03C);
        rd(8'h10, 10'h000);
        calm();
        flt(1, 8'hFF, 8'h00, 7'h00, 8'h00, 10'h080, 4'h8);
        flt(1, 8'hFE, 8'h00, 7'h00, 8'h00, 10'h000, 4'h0);
        flt(1, 8'h80, 8'h2A, 7'h21, 8'h00, 10'h040, 4'h4);
        flt(1, 8'h80, 8'h29, 7'h21, 8'h00, 10'h000, 4'h0);
        flt(1, 8'h80, 8'h7F, 7'h20, 8'h00, 10'h000, 4'h0);
        flt(2, 8'h80, 8'h2A, 7'h21, 8'h00, 10'h004, 4'h4);
        flt(1, 8'h10, 8'h18, 7'h21, 8'h20, 10'h030, 4'h2);
        flt(2, 8'h10, 8'h18, 7'h21, 8'h20, 10'h003, 4'h2);
        flt(0, 8'hC9, 8'h00, 7'h00, 8'h00, 10'h100, 4'h1);
        flt(0, 8'hC8, 8'h00, 7'h00, 8'h00, 10'h000, 4'h0);
        // supervisor level passes a synchroniser before it latches
        ot = 1'b1;
        repeat (8) @(negedge clk_i);
        rd(OFS_FAULT_STATUS, 10'h200);
        chk("summary", 10'h001, {6'h00, sum});
        ot = 1'b0;
        repeat (8) @(negedge clk_i);
        rd(OFS_FAULT_STATUS, 10'h200);
        rd(OFS_FAULT_STATUS, 10'h000);
        // clearing read and a new set land on the same edge
        meas(1, FULL_SCALE_CODE, 8'h00, 7'h00, 8'h00);
        calm();
        fork
            rd(OFS_FAULT_STATUS, 10'h080);
            meas(1, FULL_SCALE_CODE, 8'h00, 7'h00, 8'h00);
        join
        rd(OFS_FAULT_STATUS, 10'h080);
        // summary gating by the two select levels
        cs = 1'b1;
        repeat (3) @(negedge clk_i);
        chk("summary valid", 10'h000, {9'h000, sum_v});
        chk("summary", 10'h000, {6'h00, sum});
        alt = 1'b1;
        repeat (3) @(negedge clk_i);
        chk("summary valid", 10'h001, {9'h000, sum_v});
        chk("summary", 10'h008, {6'h00, sum});
        calm();
        rd(OFS_FAULT_STATUS, 10'h080);
        rd(OFS_FAULT_STATUS, 10'h000);
        chk("summary", 10'h000, {6'h00, sum});
        print_verdict();
    end
endmodule : tb

// ==== inc/fault_mon_pkg.sv ====
// package for the led monitor and fault status register group
// shared offsets, field positions, reset values and carrier structs
package fault_mon_pkg;

    // register offsets on the serial register port
    localparam logic [7:0] OFS_LED_CURRENT_CH2 = 8'h0D;
    localparam logic [7:0] OFS_DIE_TEMPERATURE = 8'h0E;
    localparam logic [7:0] OFS_FAULT_STATUS = 8'h0F;

    localparam int RESULT_W = 8;
    localparam int SETTING_W = 7;
    localparam int STATUS_W = 10;
    localparam int SUMMARY_W = 4;

    // field positions inside the fault status word
    localparam int BIT_OVERHEAT_SHUTDOWN = 9;
    localparam int BIT_OVERHEAT_WARNING = 8;
    localparam int BIT_CH1_BASE = 4;
    localparam int BIT_CH2_BASE = 0;
    localparam int OFS_OVERVOLTAGE = 3;
    localparam int OFS_OVERCURRENT = 2;
    localparam int OFS_SHORT = 1;
    localparam int OFS_OPEN = 0;

    // summary bit positions
    localparam int SUM_OVERVOLTAGE = 3;
    localparam int SUM_OVERCURRENT = 2;
    localparam int SUM_STRING = 1;
    localparam int SUM_THERMAL = 0;

    // reset values
    localparam logic [7:0] RESULT_RESET = 8'h00;
    localparam logic [9:0] STATUS_RESET = 10'h000;

    // detection constants
    localparam logic [7:0] FULL_SCALE_CODE = 8'hFF;
    localparam logic [6:0] CHECK_ENABLE_MIN = 7'h21;
    localparam logic [7:0] WARN_THRESHOLD_DEFAULT = 8'hC8;

    // per channel measurement bundle
    typedef struct packed {
        logic [7:0] voltage_code;
        logic [7:0] current_code;
        logic [6:0] current_setting;
        logic [7:0] short_threshold;
    } channel_meas_type;

    // per channel fault conditions, order: ov, oc, short, open
    typedef struct packed {
        logic overvoltage;
        logic overcurrent;
        logic short_string;
        logic open_string;
    } channel_fault_type;

endpackage : fault_mon_pkg

// ==== logic/channel_fault_detect.sv ====
// combinational fault condition detector for one led channel
// assumes results are stable while the store strobe is high
`timescale 1ns/1ps
module channel_fault_detect (
    input wire fault_mon_pkg::channel_meas_type meas_i,
    output fault_mon_pkg::channel_fault_type cond_o
);
    import fault_mon_pkg::*;

    wire check_enable;
    wire [9:0] current_x4;
    wire [9:0] setting_x5;
    wire [9:0] setting_x3;

    // low settings leave no margin, so the current and short comparisons are skipped
    assign check_enable = (meas_i.current_setting >= CHECK_ENABLE_MIN);
    // scale both sides by four to compare against 1.25 and 0.75 exactly
    assign current_x4 = {meas_i.current_code, 2'b00};
    assign setting_x5 = {1'b0, meas_i.current_setting, 2'b00} + {3'b000, meas_i.current_setting};
    assign setting_x3 = {2'b00, meas_i.current_setting, 1'b0} + {3'b000, meas_i.current_setting};

    wire cond_ov;
    wire cond_oc;
    wire cond_short;
    wire cond_open;

    // conditions only; latching lives in the status register
    assign cond_ov = (meas_i.voltage_code == FULL_SCALE_CODE);
    assign cond_oc = check_enable && (current_x4 > setting_x5);
    assign cond_short = check_enable && (meas_i.voltage_code < meas_i.short_threshold);
    assign cond_open = check_enable && (current_x4 < setting_x3);
    // one driver for the whole struct, some tools refuse per member assigns
    assign cond_o = {cond_ov, cond_oc, cond_short, cond_open};

endmodule : channel_fault_detect

// ==== logic/led_monitor_fault_status.sv ====
// led monitor and fault status register group, device side
// assumes a register port from the serial front end and result strobes from the adc sequencer
`timescale 1ns/1ps
module led_monitor_fault_status #(
    parameter logic [7:0] WARN_THRESHOLD = fault_mon_pkg::WARN_THRESHOLD_DEFAULT
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic reg_read_i,
    output logic [9:0] reg_rdata_o,
    output logic reg_rvalid_o,
    input wire logic ch1_store_i,
    input wire logic [7:0] output_voltage_code_ch1_i,
    input wire logic [7:0] current_code_ch1_i,
    input wire logic [6:0] current_setting_ch1_i,
    input wire logic [7:0] short_threshold_ch1_i,
    input wire logic ch2_store_i,
    input wire logic [7:0] output_voltage_code_ch2_i,
    input wire logic [7:0] current_code_ch2_i,
    input wire logic [6:0] current_setting_ch2_i,
    input wire logic [7:0] short_threshold_ch2_i,
    input wire logic temp_store_i,
    input wire logic [7:0] temp_code_i,
    input wire logic overtemp_pin_i,
    input wire logic channel_select_setting_i,
    input wire logic status_alternate_select_i,
    output logic [3:0] summary_fault_bits_o,
    output logic summary_valid_o
);
    import fault_mon_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // result registers

    logic [7:0] led_current_register_ch2_q;
    logic [7:0] die_temperature_result_q;

    // results are captured as the sequencer stores them
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            led_current_register_ch2_q <= RESULT_RESET;
            die_temperature_result_q <= RESULT_RESET;
        end else begin
            if (ch2_store_i) begin
                led_current_register_ch2_q <= current_code_ch2_i;
            end
            if (temp_store_i) begin
                die_temperature_result_q <= temp_code_i;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // supervisor pin synchroniser, three stages, change counts when last two agree

    logic [2:0] overtemp_sync_q;
    logic overtemp_level_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            overtemp_sync_q <= 3'b000;
            overtemp_level_q <= 1'b0;
        end else begin
            overtemp_sync_q <= {overtemp_sync_q[1:0], overtemp_pin_i};
            if (overtemp_sync_q[1] == overtemp_sync_q[2]) begin
                overtemp_level_q <= overtemp_sync_q[2];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // condition detection

    channel_meas_type meas_ch1;
    channel_meas_type meas_ch2;
    channel_fault_type cond_ch1;
    channel_fault_type cond_ch2;

    assign meas_ch1 = '{output_voltage_code_ch1_i, current_code_ch1_i,
                        current_setting_ch1_i, short_threshold_ch1_i};
    assign meas_ch2 = '{output_voltage_code_ch2_i, current_code_ch2_i,
                        current_setting_ch2_i, short_threshold_ch2_i};

    channel_fault_detect u_detect_ch1 (
        .meas_i(meas_ch1),
        .cond_o(cond_ch1)
    );

    channel_fault_detect u_detect_ch2 (
        .meas_i(meas_ch2),
        .cond_o(cond_ch2)
    );

    ////////////////////////////////////////////////////////////////////////////
    // fault status word: per bit condition, evaluation strobe and read clear

    wire [9:0] cond_vec;
    wire [9:0] eval_vec;
    wire [9:0] fault_status_word;
    wire status_read;
    wire warn_cond;

    // shutdown follows the analog supervisor only, sampled every cycle
    assign warn_cond = (temp_code_i > WARN_THRESHOLD);
    assign cond_vec = {overtemp_level_q, warn_cond, cond_ch1, cond_ch2};
    assign eval_vec = {1'b1, temp_store_i, {4{ch1_store_i}}, {4{ch2_store_i}}};
    assign status_read = reg_read_i && (reg_addr_i == OFS_FAULT_STATUS);

    // no shutdown path exists here; overcurrent is only reported
    genvar gi;
    generate
        for (gi = 0; gi < STATUS_W; gi++) begin : g_flag
            sticky_flag u_flag (
                .clk_i(clk_i),
                .rst_i(rst_i),
                .eval_i(eval_vec[gi]),
                .cond_i(cond_vec[gi]),
                .clear_i(status_read),
                .flag_o(fault_status_word[gi])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // summary bits

    wire [3:0] summary_d;
    wire summary_enable;

    assign summary_d[SUM_OVERVOLTAGE] = fault_status_word[BIT_CH1_BASE + OFS_OVERVOLTAGE]
                                      | fault_status_word[BIT_CH2_BASE + OFS_OVERVOLTAGE];
    assign summary_d[SUM_OVERCURRENT] = fault_status_word[BIT_CH1_BASE + OFS_OVERCURRENT]
                                      | fault_status_word[BIT_CH2_BASE + OFS_OVERCURRENT];
    assign summary_d[SUM_STRING] = fault_status_word[BIT_CH1_BASE + OFS_SHORT]
                                 | fault_status_word[BIT_CH2_BASE + OFS_SHORT]
                                 | fault_status_word[BIT_CH1_BASE + OFS_OPEN]
                                 | fault_status_word[BIT_CH2_BASE + OFS_OPEN];
    assign summary_d[SUM_THERMAL] = fault_status_word[BIT_OVERHEAT_SHUTDOWN]
                                  | fault_status_word[BIT_OVERHEAT_WARNING];
    assign summary_enable = !channel_select_setting_i || status_alternate_select_i;

    // registered summary, one cycle behind the flags
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            summary_fault_bits_o <= 4'h0;
            summary_valid_o <= 1'b0;
        end else begin
            summary_fault_bits_o <= summary_enable ? summary_d : 4'h0;
            summary_valid_o <= summary_enable;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read port, answers one cycle after the read strobe

    logic [9:0] rdata_mux;

    // unmapped offsets read as zero so the front end never sees stale data
    always_comb begin
        rdata_mux = 10'h000;
        unique case (reg_addr_i)
            OFS_LED_CURRENT_CH2: rdata_mux = {2'b00, led_current_register_ch2_q};
            OFS_DIE_TEMPERATURE: rdata_mux = {2'b00, die_temperature_result_q};
            OFS_FAULT_STATUS: rdata_mux = fault_status_word;
            default: rdata_mux = 10'h000;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            reg_rdata_o <= STATUS_RESET;
            reg_rvalid_o <= 1'b0;
        end else begin
            reg_rvalid_o <= reg_read_i;
            if (reg_read_i) begin
                reg_rdata_o <= rdata_mux;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // assertions

    sequence s_ovp_store;
        ch1_store_i && (output_voltage_code_ch1_i == FULL_SCALE_CODE);
    endsequence

    a_ovp_flag_set: assert property (@(posedge clk_i) disable iff (rst_i)
        s_ovp_store |=> fault_status_word[7])
        else $error("ch1 overvoltage flag not set");

    a_set_beats_clear: assert property (@(posedge clk_i) disable iff (rst_i)
        (ch2_store_i && cond_ch2.open_string && status_read) |=> fault_status_word[0])
        else $error("set lost against read");

    a_read_clears_gone: assert property (@(posedge clk_i) disable iff (rst_i)
        (status_read && !ch1_store_i && !g_flag[6].u_flag.cond_q) |=> !fault_status_word[6])
        else $error("overcurrent flag not cleared");

    a_flag_holds_cond: assert property (@(posedge clk_i) disable iff (rst_i)
        (fault_status_word[4] && g_flag[4].u_flag.cond_q && !ch1_store_i) |=> fault_status_word[4])
        else $error("open flag cleared while present");

    a_oc_disabled_low: assert property (@(posedge clk_i) disable iff (rst_i)
        (current_setting_ch1_i < CHECK_ENABLE_MIN) |-> !cond_ch1.overcurrent && !cond_ch1.open_string)
        else $error("check active below enable setting");

    a_summary_ovp: assert property (@(posedge clk_i) disable iff (rst_i)
        summary_enable |=> summary_fault_bits_o[3] == $past(fault_status_word[7] | fault_status_word[3]))
        else $error("summary overvoltage mismatch");

    a_summary_therm: assert property (@(posedge clk_i) disable iff (rst_i)
        summary_enable |=> summary_fault_bits_o[0] == $past(|fault_status_word[9:8]))
        else $error("summary thermal mismatch");

    a_summary_gate: assert property (@(posedge clk_i) disable iff (rst_i)
        (channel_select_setting_i && !status_alternate_select_i) |=> !summary_valid_o)
        else $error("summary given in alternate mode");

    a_temp_readback: assert property (@(posedge clk_i) disable iff (rst_i)
        (temp_store_i ##1 (reg_read_i && reg_addr_i == OFS_DIE_TEMPERATURE && !temp_store_i))
        |=> reg_rdata_o[7:0] == $past(temp_code_i, 2))
        else $error("temperature readback wrong");

endmodule : led_monitor_fault_status

// ==== logic/sticky_flag.sv ====
// one latched fault flag, cleared on read when the condition is gone
// assumes cond_i is only meaningful when eval_i pulses
`timescale 1ns/1ps
module sticky_flag (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic eval_i,
    input wire logic cond_i,
    input wire logic clear_i,
    output logic flag_o
);
    logic flag_d;
    logic flag_q;
    logic cond_q;
    wire set_now;
    wire clear_ok;

    // set wins over a read in the same cycle
    assign set_now = eval_i && cond_i;
    // a read leaves the flag while the last seen condition persists
    assign clear_ok = clear_i && !cond_q;
    assign flag_d = set_now ? 1'b1 : (clear_ok ? 1'b0 : flag_q);
    assign flag_o = flag_q;

    // flag and the last evaluated condition level
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flag_q <= 1'b0;
            cond_q <= 1'b0;
        end else begin
            flag_q <= flag_d;
            if (eval_i) begin
                cond_q <= cond_i;
            end
        end
    end

endmodule : sticky_flag
